/* src/csb_pkg.sv */
// Purpose: shared constants and types of the core system bus interface
// Assumes: AHB-Lite master signalling, one clock domain
// Notes: only single non-sequential transfers are ever produced
package csb_pkg;

    // ahb-lite encodings
    localparam logic [1:0] CSB_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] CSB_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CSB_HBURST_SINGLE = 3'h0;
    localparam logic [2:0] CSB_HSIZE_HALF = 3'h1;
    localparam logic [2:0] CSB_HSIZE_WORD = 3'h2;
    localparam logic [3:0] CSB_HPROT_FETCH = 4'h2;
    localparam logic [3:0] CSB_HPROT_DATA = 4'h3;

    // fetch-ahead capacity in bits
    localparam int CSB_FETCH_AHEAD_BITS = 32;

    // reset values
    localparam logic [31:0] CSB_RST_WORD = 32'h0000_0000;
    localparam logic [2:0] CSB_RST_SIZE = 3'h0;

    // single-cycle port region defaults
    localparam logic [31:0] CSB_IO_BASE_DEF = 32'hf000_0000;
    localparam logic [31:0] CSB_IO_MASK_DEF = 32'hf000_0000;

    // transfer sequencer states
    typedef enum logic [2:0] {
        CSB_ST_IDLE,
        CSB_ST_ADDR,
        CSB_ST_DATA,
        CSB_ST_IO,
        CSB_ST_DONE
    } csb_state_t;

    // owner of the transfer in flight
    typedef enum logic [1:0] {
        CSB_SRC_FETCH,
        CSB_SRC_DATA,
        CSB_SRC_DBG
    } csb_src_t;

endpackage

/* src/csb_fetch_slot.sv */
// Purpose: holds fetched instruction bits ahead of execution
// Assumes: filled only while empty, one fill per fetch
// Notes: capacity never exceeds the fetch-ahead limit
`timescale 1ns/10ps
module csb_fetch_slot
    import csb_pkg::*;
#(
    parameter int WIDTH = CSB_FETCH_AHEAD_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fill_valid,
    input wire logic [WIDTH-1:0] fill_data,
    input wire logic fill_half,
    input wire logic flush,
    input wire logic take,
    output logic slot_free,
    output logic instr_valid,
    output logic [WIDTH-1:0] instr_data,
    output logic instr_half
);

    // refuse a slot wider than the fetch-ahead limit
    if (WIDTH > CSB_FETCH_AHEAD_BITS || WIDTH < 16) begin : g_chk
        $error("csb_fetch_slot: WIDTH out of range");
    end

    logic valid_q;
    logic half_q;
    logic [WIDTH-1:0] data_q;

    assign slot_free = ~valid_q;
    assign instr_valid = valid_q;
    assign instr_data = data_q;
    assign instr_half = half_q;

    // one entry: flush and take empty it, fill loads it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            half_q <= 1'b0;
            data_q <= '0;
        end else if (flush || (take && valid_q)) begin
            valid_q <= 1'b0;
        end else if (fill_valid && !valid_q) begin
            valid_q <= 1'b1;
            half_q <= fill_half;
            data_q <= fill_data;
        end
    end

endmodule

/* src/csb_bus_if.sv */
// Purpose: merges fetch, data and debug traffic onto one ahb-lite master, data and debug io region hits onto the single-cycle port
// Assumes: core data_req and fetch_req held until served; ahb slaves same clock
// Notes: one transfer at a time, no address pipelining
`timescale 1ns/10ps
module csb_bus_if
    import csb_pkg::*;
#(
    parameter bit FETCH32 = 1'b1,
    parameter bit IO_PRESENT = 1'b1,
    parameter logic [31:0] IO_BASE = CSB_IO_BASE_DEF,
    parameter logic [31:0] IO_MASK = CSB_IO_MASK_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_flush,
    input wire logic instr_take,
    output logic instr_valid,
    output logic [31:0] instr_data,
    output logic instr_half,
    input wire logic data_req,
    input wire logic [31:0] data_addr,
    input wire logic data_write,
    input wire logic [2:0] data_size,
    input wire logic [31:0] data_wdata,
    output logic data_ack,
    output logic [31:0] data_rdata,
    output logic data_err,
    input wire logic dbg_req,
    input wire logic [31:0] dbg_addr,
    input wire logic dbg_write,
    input wire logic [2:0] dbg_size,
    input wire logic [31:0] dbg_wdata,
    output logic dbg_busy,
    output logic dbg_ack,
    output logic [31:0] dbg_rdata,
    output logic dbg_err,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [2:0] hburst,
    output logic [3:0] hprot,
    output logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    input wire logic hresp,
    output logic io_sel,
    output logic [31:0] io_addr,
    output logic io_write,
    output logic [2:0] io_size,
    output logic [31:0] io_wdata,
    input wire logic [31:0] io_rdata
);

    // refuse an empty single-cycle port region
    if (IO_PRESENT && IO_MASK == 32'h0000_0000) begin : g_chk
        $error("csb_bus_if: IO_MASK must select a region");
    end

    // single-cycle port address decode
    function automatic logic io_hit(input logic [31:0] addr);
        io_hit = IO_PRESENT && ((addr & IO_MASK) == IO_BASE);
    endfunction

    csb_state_t state_q;
    csb_src_t src_q;
    logic [31:0] cur_addr_q;
    logic [31:0] cur_wdata_q;
    logic cur_write_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic discard_q;
    logic dbg_busy_q;
    logic [31:0] dbg_addr_q;
    logic [31:0] dbg_wdata_q;
    logic dbg_write_q;
    logic [2:0] dbg_size_q;
    logic data_ack_q;
    logic dbg_ack_q;
    logic [31:0] haddr_q;
    logic [1:0] htrans_q;
    logic hwrite_q;
    logic [2:0] hsize_q;
    logic [3:0] hprot_q;
    logic [31:0] hwdata_q;
    logic io_sel_q;
    logic [31:0] io_addr_q;
    logic io_write_q;
    logic [2:0] io_size_q;
    logic [31:0] io_wdata_q;
    logic slot_free;

    // arbitration: core data, then fetch, then held debug access
    wire idle = (state_q == CSB_ST_IDLE);
    wire go_fetch = fetch_req && slot_free && !fetch_flush;
    wire core_go = data_req || go_fetch;
    wire dbg_go = dbg_busy_q && !core_go;
    wire any_go = core_go || dbg_go;
    wire csb_src_t pick_src = data_req ? CSB_SRC_DATA :
                              (go_fetch ? CSB_SRC_FETCH : CSB_SRC_DBG);

    // selected request fields
    wire [31:0] pick_addr = data_req ? data_addr :
                            (go_fetch ? {fetch_addr[31:1], 1'b0} : dbg_addr_q);
    wire pick_write = data_req ? data_write : (go_fetch ? 1'b0 : dbg_write_q);
    wire [31:0] pick_wdata = data_req ? data_wdata : dbg_wdata_q;
    wire [2:0] fetch_size = (FETCH32 && !fetch_addr[1]) ? CSB_HSIZE_WORD :
                            CSB_HSIZE_HALF;
    wire [2:0] pick_size = data_req ? data_size : (go_fetch ? fetch_size : dbg_size_q);
    wire pick_io = (pick_src != CSB_SRC_FETCH) && io_hit(pick_addr);
    wire [3:0] pick_prot = (pick_src == CSB_SRC_FETCH) ? CSB_HPROT_FETCH : CSB_HPROT_DATA;

    // fetched lane extraction into the slot
    wire fetch_is_half = (hsize_q == CSB_HSIZE_HALF);
    wire [31:0] fill_data = fetch_is_half ?
                            {16'h0000, cur_addr_q[1] ? rdata_q[31:16] : rdata_q[15:0]} :
                            rdata_q;
    wire fill_valid = (state_q == CSB_ST_DONE) && (src_q == CSB_SRC_FETCH) &&
                      !discard_q && !fetch_flush;
    wire done_fetch = (state_q == CSB_ST_DONE) && (src_q == CSB_SRC_FETCH);
    wire fetch_busy = !idle && (src_q == CSB_SRC_FETCH);

    // debug slave port: take one access while free, hold it until served
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_busy_q <= 1'b0;
            dbg_addr_q <= CSB_RST_WORD;
            dbg_wdata_q <= CSB_RST_WORD;
            dbg_write_q <= 1'b0;
            dbg_size_q <= CSB_RST_SIZE;
        end else if (dbg_ack_q) begin
            dbg_busy_q <= 1'b0;
        end else if (dbg_req && !dbg_busy_q) begin
            dbg_busy_q <= 1'b1;
            dbg_addr_q <= dbg_addr;
            dbg_wdata_q <= dbg_wdata;
            dbg_write_q <= dbg_write;
            dbg_size_q <= dbg_size;
        end
    end

    // stale fetch in flight after a flush is thrown away
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_q <= 1'b0;
        end else if (done_fetch) begin
            discard_q <= 1'b0;
        end else if (fetch_flush && fetch_busy) begin
            discard_q <= 1'b1;
        end
    end

    // transfer sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CSB_ST_IDLE;
            src_q <= CSB_SRC_DATA;
            cur_addr_q <= CSB_RST_WORD;
            cur_wdata_q <= CSB_RST_WORD;
            cur_write_q <= 1'b0;
            rdata_q <= CSB_RST_WORD;
            err_q <= 1'b0;
            data_ack_q <= 1'b0;
            dbg_ack_q <= 1'b0;
            haddr_q <= CSB_RST_WORD;
            htrans_q <= CSB_HTRANS_IDLE;
            hwrite_q <= 1'b0;
            hsize_q <= CSB_RST_SIZE;
            hprot_q <= CSB_HPROT_DATA;
            hwdata_q <= CSB_RST_WORD;
            io_sel_q <= 1'b0;
            io_addr_q <= CSB_RST_WORD;
            io_write_q <= 1'b0;
            io_size_q <= CSB_RST_SIZE;
            io_wdata_q <= CSB_RST_WORD;
        end else begin
            data_ack_q <= 1'b0;
            dbg_ack_q <= 1'b0;
            unique case (state_q)
                CSB_ST_IDLE: begin
                    if (any_go) begin
                        src_q <= pick_src;
                        cur_addr_q <= pick_addr;
                        cur_wdata_q <= pick_wdata;
                        cur_write_q <= pick_write;
                        if (pick_io) begin
                            io_sel_q <= 1'b1;
                            io_addr_q <= pick_addr;
                            io_write_q <= pick_write;
                            io_size_q <= pick_size;
                            io_wdata_q <= pick_wdata;
                            state_q <= CSB_ST_IO;
                        end else begin
                            htrans_q <= CSB_HTRANS_NONSEQ;
                            haddr_q <= pick_addr;
                            hwrite_q <= pick_write;
                            hsize_q <= pick_size;
                            hprot_q <= pick_prot;
                            state_q <= CSB_ST_ADDR;
                        end
                    end
                end
                CSB_ST_ADDR: begin
                    if (hready) begin
                        htrans_q <= CSB_HTRANS_IDLE;
                        hwdata_q <= cur_wdata_q;
                        state_q <= CSB_ST_DATA;
                    end
                end
                CSB_ST_DATA: begin
                    if (hready) begin
                        rdata_q <= hrdata;
                        err_q <= hresp;
                        data_ack_q <= (src_q == CSB_SRC_DATA);
                        dbg_ack_q <= (src_q == CSB_SRC_DBG);
                        state_q <= CSB_ST_DONE;
                    end
                end
                CSB_ST_IO: begin
                    io_sel_q <= 1'b0;
                    rdata_q <= cur_write_q ? CSB_RST_WORD : io_rdata;
                    err_q <= 1'b0;
                    data_ack_q <= (src_q == CSB_SRC_DATA);
                    dbg_ack_q <= (src_q == CSB_SRC_DBG);
                    state_q <= CSB_ST_DONE;
                end
                CSB_ST_DONE: begin
                    state_q <= CSB_ST_IDLE;
                end
                default: begin
                    state_q <= CSB_ST_IDLE;
                end
            endcase
        end
    end

    // instruction slot, limited to the fetch-ahead capacity
    csb_fetch_slot #(
        .WIDTH(CSB_FETCH_AHEAD_BITS)
    ) u_slot (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .fill_valid(fill_valid),
        .fill_data(fill_data),
        .fill_half(fetch_is_half),
        .flush(fetch_flush),
        .take(instr_take),
        .slot_free(slot_free),
        .instr_valid(instr_valid),
        .instr_data(instr_data),
        .instr_half(instr_half)
    );

    // outputs straight from flops, hburst tied to CSB_HBURST_SINGLE
    assign haddr = haddr_q;
    assign htrans = htrans_q;
    assign hwrite = hwrite_q;
    assign hsize = hsize_q;
    assign hburst = CSB_HBURST_SINGLE;
    assign hprot = hprot_q;
    assign hwdata = hwdata_q;
    assign io_sel = io_sel_q;
    assign io_addr = io_addr_q;
    assign io_write = io_write_q;
    assign io_size = io_size_q;
    assign io_wdata = io_wdata_q;
    assign data_ack = data_ack_q;
    assign data_rdata = rdata_q;
    assign data_err = err_q;
    assign dbg_busy = dbg_busy_q;
    assign dbg_ack = dbg_ack_q;
    assign dbg_rdata = rdata_q;
    assign dbg_err = err_q;

endmodule

/* verification/csb_bus_if_chk.sv */
// Purpose: port-level assertions of the bus interface
// Assumes: single clock, async active-low reset
// Notes: bound from the bench top
`timescale 1ns/10ps
module csb_bus_if_chk
    import csb_pkg::*;
#(
    parameter bit FETCH32 = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fetch_req,
    input wire logic instr_valid,
    input wire logic data_req,
    input wire logic [31:0] data_addr,
    input wire logic data_ack,
    input wire logic dbg_busy,
    input wire logic dbg_ack,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic [2:0] hburst,
    input wire logic [3:0] hprot,
    input wire logic io_sel
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // transfer kind decode
    wire logic ns = htrans == CSB_HTRANS_NONSEQ;
    wire logic f_ns = ns && hprot == CSB_HPROT_FETCH;
    wire logic [2:0] f_size = (FETCH32 && !haddr[1]) ? CSB_HSIZE_WORD : CSB_HSIZE_HALF;

    a_only_nonseq: assert property ((ns || htrans == CSB_HTRANS_IDLE)
        && hburst == CSB_HBURST_SINGLE) else $error("burst or seq transfer");
    a_core_first: assert property ($rose(ns) && $past(data_req) |->
        haddr == $past(data_addr) && hprot == CSB_HPROT_DATA) else $error("core not first");
    a_no_fetch_io: assert property (io_sel |->
        $past(data_req) || $past(dbg_busy)) else $error("fetch on io port");
    a_slot_limit: assert property (f_ns |-> !instr_valid) else $error("fetch ahead too far");
    a_io_answer: assert property (io_sel |=> (data_ack || dbg_ack) && !io_sel)
        else $error("io access not answered");
    a_fetch_width: assert property (f_ns |-> hsize == f_size) else $error("fetch size");
    a_dbg_close: assert property (dbg_ack |-> dbg_busy ##1 !dbg_busy)
        else $error("debug ack framing");
    a_dbg_kept: assert property (dbg_busy && !dbg_ack |=> dbg_busy)
        else $error("debug access dropped");
    a_dbg_prompt: assert property ($rose(dbg_busy) && !data_req && !fetch_req |->
        ##[2:12] dbg_ack) else $error("debug not issued when core idle");
endmodule

/* verification/csb_ahb_mem.sv */
// Purpose: ahb-lite memory and single-cycle port model
// Assumes: 16 words, no error responses
// Notes: slow inserts a wait state on alternate cycles
`timescale 1ns/10ps
module csb_ahb_mem
    import csb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hready,
    output logic hresp,
    input wire logic io_sel,
    input wire logic [31:0] io_addr,
    output logic [31:0] io_rdata
);
    logic [31:0] mem_q [16];
    logic [3:0] idx_q;
    logic dph_q, wr_q, tog_q;
    // answers; read lines scrambled outside the data phase
    assign hready = !slow || tog_q;
    assign hresp = 1'h0;
    assign hrdata = dph_q ? mem_q[idx_q] : ~mem_q[idx_q];
    assign io_rdata = io_sel ? ~io_addr : io_addr;
    // phase tracking and storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dph_q <= 1'h0;
            wr_q <= 1'h0;
            idx_q <= 4'h0;
            tog_q <= 1'h0;
            for (int i = 0; i < 16; i++) mem_q[i] <= {4'(i), 28'h5a3_c961};
        end else begin
            tog_q <= !tog_q;
            if (hready) begin
                dph_q <= htrans == CSB_HTRANS_NONSEQ;
                idx_q <= haddr[5:2];
                wr_q <= hwrite;
                if (dph_q && wr_q) mem_q[idx_q] <= hwdata;
            end
        end
    end
endmodule

/* verification/csb_bus_if_tb_top.sv */
// Purpose: self-checking bench of the core system bus interface
// Assumes: memory model answers every transfer
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module csb_bus_if_tb_top
    import csb_pkg::*;
;
    logic sys_clk = 1'h0, rst_n = 1'h0, slow = 1'h0, fetch_req = 1'h0;
    logic fetch_flush = 1'h0, instr_take = 1'h0, data_req = 1'h0, data_write = 1'h0;
    logic dbg_req = 1'h0, dbg_write = 1'h0;
    logic [31:0] fetch_addr = '0, data_addr = '0, data_wdata = '0, dbg_addr = '0;
    logic [31:0] dbg_wdata = '0, rd, instr_data, data_rdata, dbg_rdata, haddr, hwdata;
    logic [31:0] hrdata, io_addr, io_wdata, io_rdata;
    logic [2:0] data_size = CSB_HSIZE_WORD, dbg_size = CSB_HSIZE_WORD, hsize, hburst, io_size;
    logic instr_valid, instr_half, data_ack, data_err, dbg_busy, dbg_ack, dbg_err;
    logic hwrite, hready, hresp, io_sel, io_write;
    logic [1:0] htrans;
    logic [3:0] hprot;
    logic [31:0] ns_log [64];
    int fail_count = 0, tests_run = 0, cyc = 0, io_cnt = 0, n_ns = 0, n0, c0;

    csb_bus_if dut (.sys_clk, .rst_n, .fetch_req, .fetch_addr, .fetch_flush, .instr_take,
        .instr_valid, .instr_data, .instr_half, .data_req, .data_addr, .data_write,
        .data_size, .data_wdata, .data_ack, .data_rdata, .data_err, .dbg_req, .dbg_addr,
        .dbg_write, .dbg_size, .dbg_wdata, .dbg_busy, .dbg_ack, .dbg_rdata, .dbg_err,
        .haddr, .htrans, .hwrite, .hsize, .hburst, .hprot, .hwdata, .hrdata, .hready,
        .hresp, .io_sel, .io_addr, .io_write, .io_size, .io_wdata, .io_rdata);
    csb_ahb_mem mem (.sys_clk, .rst_n, .slow, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
        .hready, .hresp, .io_sel, .io_addr, .io_rdata);

    initial forever #2.5 sys_clk = ~sys_clk;
    // log accepted ahb addresses, count io selects, cut hangs
    always @(posedge sys_clk) begin
        cyc++;
        if (io_sel === 1'h1) io_cnt++;
        if (htrans === CSB_HTRANS_NONSEQ && hready === 1'h1) begin
            ns_log[n_ns[5:0]] = haddr;
            n_ns++;
        end
        if (cyc > 3000) begin
            fail_count++;
            print_verdict();
        end
    end

    function automatic logic [31:0] mv(input logic [3:0] i);
        return {i, 28'h5a3_c961};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // k selects the answer: 0 data_ack, 1 dbg_ack, 2 instr_valid
    task automatic wait_hi(input int k);
        repeat (60) begin
            @(posedge sys_clk);
            #1;
            if ((k == 0 && data_ack === 1'h1) || (k == 1 && dbg_ack === 1'h1) ||
                (k == 2 && instr_valid === 1'h1)) return;
        end
        chk("handshake", 32'h1, 32'h0);
    endtask
    task automatic core_acc(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(negedge sys_clk);
        {data_req, data_write, data_addr, data_wdata} = {1'h1, w, a, d};
        wait_hi(0);
        r = data_rdata;
        @(posedge sys_clk);
        @(negedge sys_clk);
        data_req = 1'h0;
        data_addr = ~a;
    endtask
    task automatic dbg_acc(input logic [31:0] a, output logic [31:0] r);
        @(negedge sys_clk);
        {dbg_req, dbg_write, dbg_addr} = {1'h1, 1'h0, a};
        @(negedge sys_clk);
        dbg_req = 1'h0;
        dbg_addr = ~a;
        wait_hi(1);
        r = dbg_rdata;
    endtask
    task automatic fetch(input logic [31:0] a, e, input logic h);
        @(negedge sys_clk);
        {fetch_req, fetch_addr} = {1'h1, a};
        wait_hi(2);
        chk("instr_data", e, instr_data);
        chk("instr_half", {31'h0, h}, {31'h0, instr_half});
        @(negedge sys_clk);
        {fetch_req, instr_take} = 2'h1;
        @(negedge sys_clk);
        instr_take = 1'h0;
    endtask
    // write and read back, prompt and slow memory
    task automatic s_ahb();
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            core_acc(1'h1, 32'h10 + 8 * s, 32'hcafe_0000 + s, rd);
            chk("hwdata", 32'hcafe_0000 + s, hwdata);
            core_acc(1'h0, 32'h10 + 8 * s, 32'h0, rd);
            chk("ahb_rd", 32'hcafe_0000 + s, rd);
            chk("data_err", 32'h0, {31'h0, data_err});
        end
        slow = 1'h0;
    endtask
    // core and debugger reach the single-cycle port, no ahb traffic
    task automatic s_io();
        {n0, c0} = {n_ns, io_cnt};
        core_acc(1'h1, 32'hf000_0010, 32'h1234_5678, rd);
        chk("io_wdata", 32'h1234_5678, io_wdata);
        chk("io_write", 32'h1, {31'h0, io_write});
        core_acc(1'h0, 32'hf000_0020, 32'h0, rd);
        chk("io_rd", ~32'hf000_0020, rd);
        chk("io_addr", 32'hf000_0020, io_addr);
        dbg_acc(32'hf000_0030, rd);
        chk("io_dbg_rd", ~32'hf000_0030, rd);
        chk("io_cnt", c0 + 3, io_cnt);
        chk("ahb_cnt", n0, n_ns);
    endtask
    // word, upper halfword, and fetch from the io region stays on ahb
    task automatic s_fetch();
        c0 = io_cnt;
        fetch(32'h4, mv(4'h1), 1'h0);
        fetch(32'h6, {16'h0, 16'h15a3}, 1'h1);
        fetch(32'hf000_0008, mv(4'h2), 1'h0);
        chk("fetch_io_cnt", c0, io_cnt);
    endtask
    // a flush drops the fetch in flight, the next fetch still lands
    task automatic s_flush();
        @(negedge sys_clk);
        {fetch_req, fetch_addr} = {1'h1, 32'h8};
        @(negedge sys_clk);
        {fetch_req, fetch_flush} = 2'h1;
        @(negedge sys_clk);
        fetch_flush = 1'h0;
        repeat (6) @(negedge sys_clk);
        chk("flush_valid", 32'h0, {31'h0, instr_valid});
        fetch(32'hc, mv(4'h3), 1'h0);
    endtask
    // core and debug request together, core first, debug later
    task automatic s_contend();
        n0 = n_ns;
        @(negedge sys_clk);
        {data_req, data_write, data_addr} = {1'h1, 1'h0, 32'h20};
        {dbg_req, dbg_write, dbg_addr} = {1'h1, 1'h0, 32'h24};
        @(negedge sys_clk);
        dbg_req = 1'h0;
        wait_hi(0);
        chk("cont_data", mv(4'h8), data_rdata);
        @(posedge sys_clk);
        @(negedge sys_clk);
        data_req = 1'h0;
        wait_hi(1);
        chk("cont_dbg", mv(4'h9), dbg_rdata);
        chk("dbg_err", 32'h0, {31'h0, dbg_err});
        chk("first_addr", 32'h20, ns_log[n0]);
        chk("second_addr", 32'h24, ns_log[n0 + 1]);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'h1;
        s_ahb();
        s_io();
        s_fetch();
        s_flush();
        s_contend();
        print_verdict();
    end
endmodule

bind csb_bus_if csb_bus_if_chk #(.FETCH32(FETCH32)) chk_i (.sys_clk, .rst_n, .fetch_req,
    .instr_valid, .data_req, .data_addr, .data_ack, .dbg_busy, .dbg_ack, .haddr, .htrans,
    .hsize, .hburst, .hprot, .io_sel);
